// >>> pkg/ipav_pkg.sv
package ipav_pkg;

  typedef struct packed {
    logic autovector_select;
    logic [2:0] lvl;
    logic [1:0] prio;
  } ipav_icr_t;

  typedef struct packed {
    logic valid;
    logic spurious;
    logic autovec;
    logic as_block;
    logic [2:0] lvl;
    logic [3:0] src;
    logic [7:0] vector;
  } ipav_ack_t;

  typedef struct packed {
    logic [2:0] level;
    logic req;
  } ipav_iack_t;

  typedef enum logic [0:0] {
    IPAV_ST_IDLE = 1'b0,
    IPAV_ST_DATA = 1'b1
  } ipav_bus_st_t;

endpackage

// >>> pkg/ipav_regs.svh
`ifndef IPAV_REGS_SVH
`define IPAV_REGS_SVH

// word indices; the byte address is four times the index
`define IPAV_PEND_IDX 10'h040
`define IPAV_MASK_IDX 10'h044
`define IPAV_AVR_IDX 10'h048
`define IPAV_ICR_IDX 10'h04c
`define IPAV_PAR_IDX 10'h060

`define IPAV_NUM_INT 10
`define IPAV_NUM_SRC 14
`define IPAV_EXT_BASE 4'ha
`define IPAV_NO_SRC 4'hf

// source control register fields
`define IPAV_ICR_AUTOVECTOR_SELECT_BIT 7
`define IPAV_ICR_LVL_HI 4
`define IPAV_ICR_LVL_LO 2
`define IPAV_ICR_PRI_HI 1
`define IPAV_ICR_PRI_LO 0

// autovector control register fields
`define IPAV_AVR_BLK_BIT 0
// pin level assignment field, bits 7..5
`define IPAV_PAR_HI 7
`define IPAV_PAR_LO 5

`define IPAV_ICR_RST 8'h00
`define IPAV_AVR_RST 8'h00
`define IPAV_PAR_RST 3'h0
`define IPAV_MASK_RST 14'h3fff

`define IPAV_SLOTS_PER_LVL 6'h05
`define IPAV_EXT_POS 3'h2
`define IPAV_AUTOVEC_BASE 8'h60

`endif

// >>> rtl/ipav_rank.sv
// picks the pending source with the lowest slot number
module ipav_rank (
  input wire logic [13:0] req,
  input wire logic [13:0][5:0] slot,
  output logic hit,
  output logic [3:0] src
);
  logic [5:0] best;

  always_comb begin
    best = 6'h3f;
    hit = 1'b0;
    src = 4'hf;
    for (int i = 0; i < 14; i++) begin
      if (req[i] && (slot[i] < best)) begin // [RULE_03]
        best = slot[i];
        hit = 1'b1;
        src = 4'(i);
      end
    end
  end

endmodule

// >>> rtl/ipav_top.sv
// Overview of operation
// [RULE_01] software never gives two source registers the same level and priority
// [RULE_02] seven levels, five slots each; a pin sits between priority 10 and 01
// [RULE_03] priority 11 before 10 before 01 before 00; lowest slot wins
// [RULE_04] level-seven pin always takes the third slot of level 7
// [RULE_05] pin three is level 6 when middle assignment bit set, else 3
// [RULE_06] pin five is level 5 when upper assignment bit clear, else 4
// [RULE_07] pin one is level 2 when lowest assignment bit set, else 1
// [RULE_08] autovector bits 7..1 pick autovector or source vector per level
// [RULE_09] bit 0 blocks the address strobe in external autovector cycles
// [RULE_10] external autovector offset is 0x60 plus four times the level
// [RULE_11] an autovector bit counts only when its level is assigned a pin
// [RULE_12] internal sources take the autovector choice from their own register
// [RULE_13] source register: level in bits 4..2, priority in bits 1..0
// [RULE_14] source register bit 7 selects autovector for that source
// [RULE_15] present winning level to the core and answer its acknowledge
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`include "ipav_regs.svh"

module ipav_top (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [9:0] int_req,
  input wire logic ext_request_pin_one_n,
  input wire logic ext_request_pin_three_n,
  input wire logic ext_request_pin_five_n,
  input wire logic ext_request_pin_seven_n,
  input wire ipav_pkg::ipav_iack_t iack,
  output logic [2:0] ipl,
  output ipav_pkg::ipav_ack_t ack
);
  import ipav_pkg::*;

  function automatic logic [5:0] slot_of(input logic [2:0] l, input logic [2:0] p);
    slot_of = ({3'b000, 3'h7 - l} * `IPAV_SLOTS_PER_LVL) + {3'b000, p}; // [RULE_02]
  endfunction

  function automatic logic [2:0] prio_pos(input logic [1:0] pr);
    // the pin takes position 2 between priority 10 and 01
    unique case (pr)
      2'b11: prio_pos = 3'h0; // [RULE_03]
      2'b10: prio_pos = 3'h1;
      2'b01: prio_pos = 3'h3;
      2'b00: prio_pos = 3'h4;
    endcase
  endfunction

  function automatic logic [7:0] vec_off(input logic [2:0] l);
    vec_off = `IPAV_AUTOVEC_BASE + {3'b000, l, 2'b00}; // [RULE_10]
  endfunction

  // levels reachable by some pin under the given assignment
  function automatic logic [7:1] lvl_enabled(input logic [2:0] par);
    lvl_enabled = {1'b1, par[1], ~par[2], par[2], ~par[1], par[0], ~par[0]}; // [RULE_11]
  endfunction

  // registers
  ipav_icr_t icr_q [`IPAV_NUM_INT];
  logic [7:0] avr_q;
  logic [2:0] par_q;
  logic [13:0] mask_q;
  ipav_bus_st_t st_q;
  logic [9:0] ap_idx_q;
  logic ap_ok_q;
  logic ap_wr_q;
  logic hready_q;
  logic [31:0] hrdata_q;
  logic [2:0] ipl_q;
  ipav_ack_t ack_q;

  // request vector: internal sources then pins one, three, five, seven
  logic [13:0] raw_req;
  logic [13:0] eff_req;
  logic [13:0] src_ok;
  logic [13:0][2:0] lvl_w;
  logic [13:0][5:0] slot_w;
  logic [15:0] icr_autovector_select;

  assign raw_req = {~ext_request_pin_seven_n, ~ext_request_pin_five_n,
                    ~ext_request_pin_three_n, ~ext_request_pin_one_n, int_req};
  assign eff_req = raw_req & ~mask_q & src_ok;

  always_comb begin
    icr_autovector_select = 16'h0000;
    for (int i = 0; i < `IPAV_NUM_INT; i++) begin
      lvl_w[i] = icr_q[i].lvl; // [RULE_13]
      slot_w[i] = slot_of(icr_q[i].lvl, prio_pos(icr_q[i].prio));
      // level zero never requests
      src_ok[i] = (icr_q[i].lvl != 3'h0);
      icr_autovector_select[i] = icr_q[i].autovector_select; // [RULE_14]
    end
    lvl_w[10] = par_q[0] ? 3'h2 : 3'h1; // [RULE_07]
    lvl_w[11] = par_q[1] ? 3'h6 : 3'h3; // [RULE_05]
    lvl_w[12] = par_q[2] ? 3'h4 : 3'h5; // [RULE_06]
    lvl_w[13] = 3'h7; // [RULE_04]
    for (int i = 10; i < 14; i++) begin
      slot_w[i] = slot_of(lvl_w[i], `IPAV_EXT_POS); // [RULE_02]
      src_ok[i] = 1'b1;
    end
  end

  // overall winner drives the level shown to the core
  logic win_hit;
  logic [3:0] win_src;
  logic [2:0] win_lvl;

  ipav_rank u_rank_all (
    .req(eff_req),
    .slot(slot_w),
    .hit(win_hit),
    .src(win_src)
  );

  assign win_lvl = win_hit ? lvl_w[win_src] : 3'h0;

  // winner within the level being acknowledged
  logic [13:0] lvl_req;
  logic lvl_hit;
  logic [3:0] lvl_src;

  always_comb begin
    for (int i = 0; i < 14; i++) begin
      lvl_req[i] = eff_req[i] && (lvl_w[i] == iack.level);
    end
  end

  ipav_rank u_rank_lvl (
    .req(lvl_req),
    .slot(slot_w),
    .hit(lvl_hit),
    .src(lvl_src)
  );

  // acknowledge answer
  logic [7:0] autovector_select_eff;
  logic lvl_is_ext;
  logic ext_av;
  logic int_av;
  logic use_av;
  ipav_ack_t ack_d;

  assign autovector_select_eff = {avr_q[7:1] & lvl_enabled(par_q), 1'b0}; // [RULE_11]
  assign lvl_is_ext = (lvl_src >= `IPAV_EXT_BASE);
  assign ext_av = autovector_select_eff[iack.level]; // [RULE_08]
  assign int_av = icr_autovector_select[lvl_src]; // [RULE_12]
  assign use_av = lvl_hit && (lvl_is_ext ? ext_av : int_av);

  always_comb begin
    ack_d.valid = 1'b1;
    ack_d.spurious = ~lvl_hit;
    ack_d.autovec = use_av;
    // strobe stays off only for external autovector cycles
    ack_d.as_block = use_av && lvl_is_ext && avr_q[`IPAV_AVR_BLK_BIT]; // [RULE_09]
    ack_d.lvl = iack.level;
    ack_d.src = lvl_hit ? lvl_src : `IPAV_NO_SRC;
    ack_d.vector = use_av ? vec_off(iack.level) : 8'h00; // [RULE_10]
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ipl_q <= 3'h0;
    end else begin
      ipl_q <= win_lvl; // [RULE_15]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ack_q <= '0;
    end else if (iack.req) begin
      ack_q <= ack_d; // [RULE_15]
    end else begin
      ack_q <= '0;
    end
  end

  // bus slave: one wait state on every transfer
  logic sel_ok;
  logic wr_now;
  logic [9:0] icr_off;
  logic icr_hit;
  logic wr_icr;
  logic wr_avr;
  logic wr_par;
  logic wr_mask;
  logic [31:0] rd_data;

  assign sel_ok = hsel && hready && htrans[1];
  assign wr_now = (st_q == IPAV_ST_DATA) && ap_wr_q && ap_ok_q;
  assign icr_off = ap_idx_q - `IPAV_ICR_IDX;
  assign icr_hit = (ap_idx_q >= `IPAV_ICR_IDX) && (icr_off < 10'(`IPAV_NUM_INT));
  assign wr_icr = wr_now && icr_hit;
  assign wr_avr = wr_now && (ap_idx_q == `IPAV_AVR_IDX);
  assign wr_par = wr_now && (ap_idx_q == `IPAV_PAR_IDX);
  assign wr_mask = wr_now && (ap_idx_q == `IPAV_MASK_IDX);

  always_comb begin
    rd_data = 32'h0000_0000;
    if (ap_ok_q) begin
      if (icr_hit) begin
        rd_data[`IPAV_ICR_AUTOVECTOR_SELECT_BIT] = icr_q[icr_off[3:0]].autovector_select;
        rd_data[`IPAV_ICR_LVL_HI:`IPAV_ICR_LVL_LO] = icr_q[icr_off[3:0]].lvl;
        rd_data[`IPAV_ICR_PRI_HI:`IPAV_ICR_PRI_LO] = icr_q[icr_off[3:0]].prio;
      end else if (ap_idx_q == `IPAV_AVR_IDX) begin
        rd_data[7:0] = avr_q;
      end else if (ap_idx_q == `IPAV_PAR_IDX) begin
        rd_data[`IPAV_PAR_HI:`IPAV_PAR_LO] = par_q;
      end else if (ap_idx_q == `IPAV_MASK_IDX) begin
        rd_data[13:0] = mask_q;
      end else if (ap_idx_q == `IPAV_PEND_IDX) begin
        rd_data[13:0] = raw_req;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st_q <= IPAV_ST_IDLE;
      hready_q <= 1'b1;
      ap_idx_q <= 10'h000;
      ap_ok_q <= 1'b0;
      ap_wr_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
    end else begin
      unique case (st_q)
        IPAV_ST_IDLE: begin
          if (sel_ok) begin
            st_q <= IPAV_ST_DATA;
            hready_q <= 1'b0;
            ap_idx_q <= haddr[11:2];
            ap_ok_q <= (haddr[31:12] == 20'h00000) && (haddr[1:0] == 2'b00);
            ap_wr_q <= hwrite;
          end
        end
        IPAV_ST_DATA: begin
          st_q <= IPAV_ST_IDLE;
          hready_q <= 1'b1;
          hrdata_q <= ap_wr_q ? 32'h0000_0000 : rd_data;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      for (int i = 0; i < `IPAV_NUM_INT; i++) begin
        icr_q[i] <= 6'(`IPAV_ICR_RST);
      end
    end else if (wr_icr) begin
      icr_q[icr_off[3:0]] <= {hwdata[`IPAV_ICR_AUTOVECTOR_SELECT_BIT],
                              hwdata[`IPAV_ICR_LVL_HI:`IPAV_ICR_LVL_LO],
                              hwdata[`IPAV_ICR_PRI_HI:`IPAV_ICR_PRI_LO]}; // [RULE_13]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      avr_q <= `IPAV_AVR_RST;
      par_q <= `IPAV_PAR_RST;
      mask_q <= `IPAV_MASK_RST;
    end else begin
      if (wr_avr) begin
        avr_q <= hwdata[7:0]; // [RULE_08]
      end
      if (wr_par) begin
        par_q <= hwdata[`IPAV_PAR_HI:`IPAV_PAR_LO];
      end
      if (wr_mask) begin
        mask_q <= hwdata[13:0];
      end
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hready_q;
  assign hresp = 1'b0;
  assign ipl = ipl_q;
  assign ack = ack_q;

  // checks
  logic [2:0] max_lvl;
  logic hi7_any;

  always_comb begin
    max_lvl = 3'h0;
    hi7_any = 1'b0;
    for (int i = 0; i < 14; i++) begin
      if (eff_req[i] && (lvl_w[i] > max_lvl)) begin
        max_lvl = lvl_w[i];
      end
    end
    for (int i = 0; i < `IPAV_NUM_INT; i++) begin
      if (eff_req[i] && (lvl_w[i] == 3'h7) && icr_q[i].prio[1]) begin
        hi7_any = 1'b1;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  chk_ipl_max_level: // [RULE_02]
  assert property (1'b1 |=> ipl_q == $past(max_lvl))
    else $error("presented level is not the highest pending level");

  chk_pin7_slot: // [RULE_04]
  assert property (iack.req && iack.level == 3'h7 && eff_req[13] && !hi7_any
                   |=> ack_q.src == 4'hd)
    else $error("level seven pin lost its third slot");

  chk_pin3_level: // [RULE_05]
  assert property (eff_req == 14'h0800 |=> ipl_q == ($past(par_q[1]) ? 3'h6 : 3'h3))
    else $error("pin three level mapping wrong");

  chk_pin5_level: // [RULE_06]
  assert property (eff_req == 14'h1000 |=> ipl_q == ($past(par_q[2]) ? 3'h4 : 3'h5))
    else $error("pin five level mapping wrong");

  chk_pin1_level: // [RULE_07]
  assert property (eff_req == 14'h0400 |=> ipl_q == ($past(par_q[0]) ? 3'h2 : 3'h1))
    else $error("pin one level mapping wrong");

  chk_vector_offset: // [RULE_10]
  assert property (ack_q.valid && ack_q.autovec
                   |-> ack_q.vector == (8'h60 + {3'b000, ack_q.lvl, 2'b00}))
    else $error("autovector offset wrong");

  chk_strobe_block: // [RULE_09]
  assert property (iack.req ##1 ack_q.as_block
                   |-> ack_q.autovec && ack_q.src >= 4'ha && $past(avr_q[0]))
    else $error("address strobe blocked outside external autovector");

  chk_int_autovector_select_src: // [RULE_12]
  assert property (iack.req && lvl_hit && lvl_src < 4'ha
                   |=> ack_q.autovec == $past(icr_autovector_select[lvl_src]))
    else $error("internal autovector choice not from source register");

  chk_ext_autovector_select_en: // [RULE_11]
  assert property (iack.req && lvl_hit && lvl_src >= 4'ha
                   |=> ack_q.autovec == $past(avr_q[iack.level]))
    else $error("external autovector choice wrong");

  chk_ack_pulse: // [RULE_15]
  assert property (1'b1 |=> ack_q.valid == $past(iack.req))
    else $error("acknowledge answer not one cycle after request");

  chk_bus_wait:
  assert property (sel_ok && st_q == IPAV_ST_IDLE |=> !hready_q ##1 hready_q)
    else $error("bus answer timing wrong");

  cov_blocked_autovec: cover property (ack_q.valid && ack_q.as_block);
  cov_spurious_ack: cover property (ack_q.valid && ack_q.spurious);
  cov_pin3_at_six: cover property (ipl_q == 3'h6 && eff_req[11] && par_q[1]);

endmodule

// >>> sim/ipav_core_model.sv
// processor core side: issues acknowledge cycles for requested levels
module ipav_core_model (
  input wire logic core_clk,
  output ipav_pkg::ipav_iack_t iack
);
  timeunit 1ns;
  timeprecision 1ps;
  import ipav_pkg::*;
  initial iack = '0;
  // two acknowledges on consecutive edges, then the request drops
  task automatic ack_pair(input logic [2:0] a, input logic [2:0] b);
    @(posedge core_clk);
    iack <= '{level: a, req: 1'b1};
    @(posedge core_clk);
    iack <= '{level: b, req: 1'b1};
    @(posedge core_clk);
    iack <= '0;
  endtask
endmodule

// >>> sim/tb_interrupt_priority_autovector.sv
module tb_interrupt_priority_autovector;
  timeunit 1ns;
  timeprecision 1ps;
  import ipav_pkg::*;
  logic core_clk, resetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, v;
  logic [1:0] htrans;
  logic [2:0] hsize, ipl, lx, ly;
  wire logic hready = hreadyout;
  logic [9:0] int_req;
  logic [3:0] ext_n;
  ipav_iack_t iack;
  ipav_ack_t ack, e;
  logic [7:0] src_sh [10];
  logic [7:0] avr_sh, par_sh;
  logic [13:0] mask_sh;
  ipav_ack_t exp_q [$];
  int error_cnt = 0;
  int check_count = 0;
  int c, base, k;
  integer seed = 32'h195f;
  logic [31:0] ta [6] = '{32'h100, 32'h110, 32'h120, 32'h130, 32'h180, 32'h1fc};
  logic [31:0] tr [6] = '{32'h0, 32'h3fff, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0] tw [6] = '{32'h0, 32'h3fff, 32'hff, 32'h9f, 32'he0, 32'h0};
  int ks [6] = '{1, 3, 5, 9, 11, 13};

  ipav_top ipav_top_i (.core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .int_req(int_req),
    .ext_request_pin_one_n(ext_n[0]), .ext_request_pin_three_n(ext_n[1]),
    .ext_request_pin_five_n(ext_n[2]), .ext_request_pin_seven_n(ext_n[3]),
    .iack(iack), .ipl(ipl), .ack(ack));
  ipav_core_model ipav_core_model_i (.core_clk(core_clk), .iack(iack));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] want, input string m);
    check_count++;
    if (got !== want) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, got, want);
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    rd = hrdata;
    cmp({31'h0, hresp}, 32'h0, "hresp");
  endtask

  // reference answer for an acknowledge at level l
  function automatic ipav_ack_t expect_ack(input logic [2:0] l);
    ipav_ack_t r;
    logic [13:0] p;
    logic [2:0] lv, sl, best;
    logic [2:0] el [4];
    el = '{par_sh[5] ? 3'h2 : 3'h1, par_sh[6] ? 3'h6 : 3'h3,
      par_sh[7] ? 3'h4 : 3'h5, 3'h7};
    r = '0;
    r.valid = 1'b1;
    r.spurious = 1'b1;
    r.lvl = l;
    r.src = 4'hf;
    best = 3'h7;
    p = {~ext_n, int_req} & ~mask_sh;
    for (int s = 0; s < 14; s++) begin
      lv = (s < 10) ? src_sh[s][4:2] : el[s-10];
      sl = (s > 9) ? 3'h2 : src_sh[s][1] ? 3'h3 - src_sh[s][1:0] : 3'h4 - src_sh[s][1:0];
      if (p[s] && l != 3'h0 && lv == l && sl < best) begin
        best = sl;
        r.spurious = 1'b0;
        r.src = s;
      end
    end
    if (!r.spurious) begin
      r.autovec = (r.src < 10) ? src_sh[r.src][7] : avr_sh[l];
      r.as_block = (r.src > 9) && r.autovec && avr_sh[0];
      r.vector = r.autovec ? 8'h60 + {3'h0, l, 2'h0} : 8'h00;
    end
    return r;
  endfunction

  always @(posedge core_clk) begin
    if (ack.valid === 1'b1) begin
      if (exp_q.size() == 0)
        cmp(1, 0, "unexpected ack");
      else
        cmp(ack, exp_q.pop_front(), "ack");
    end
  end

  initial begin
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = '0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    int_req = '0;
    ext_n = 4'hf;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    cmp(ipl, 0, "ipl after reset");
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, ta[i], 0);
      cmp(rd, tr[i], "reset value");
      bus(1'b1, ta[i], 32'hffffffff);
      bus(1'b0, ta[i], 0);
      cmp(rd, tw[i], "readback");
    end
    $display("register access test done");
    bus(1'b1, 32'h110, 0);
    mask_sh = 14'h0000;
    avr_sh = 8'hff;
    src_sh = '{default: 8'h00};
    src_sh[0] = 8'h9f;
    // level-zero sources request but must never be ranked
    int_req <= 10'h3fe;
    for (int n = 0; n < 8; n++) begin
      par_sh = 8'(n << 5);
      bus(1'b1, 32'h180, {24'h0, par_sh});
      for (int j = 0; j < 3; j++) begin
        ext_n <= ~(4'h1 << j);
        repeat (3) @(posedge core_clk);
        lx = (j == 0) ? (par_sh[5] ? 3'h2 : 3'h1) : (j == 1) ? (par_sh[6] ? 3'h6 : 3'h3)
          : (par_sh[7] ? 3'h4 : 3'h5);
        cmp(ipl, lx, "pin level");
        exp_q.push_back(expect_ack(lx));
        exp_q.push_back(expect_ack(lx));
        ipav_core_model_i.ack_pair(lx, lx);
      end
    end
    $display("pin assignment test done");
    for (int n = 0; n < 60; n++) begin
      v = $random(seed);
      par_sh = v[7:0] & 8'he0;
      bus(1'b1, 32'h180, v);
      v = $random(seed);
      avr_sh = v[7:0];
      bus(1'b1, 32'h120, v);
      v = $random(seed) & $random(seed);
      mask_sh = v[13:0];
      bus(1'b1, 32'h110, v);
      base = {$random(seed)} % 28;
      k = ks[{$random(seed)} % 6];
      for (int i = 0; i < 10; i++) begin
        c = (base + i * k) % 28; // distinct level and priority per source
        v = $random(seed);
        v[4:2] = c / 4 + 1;
        v[1:0] = c % 4;
        src_sh[i] = v[7:0] & 8'h9f;
        bus(1'b1, 32'h130 + 4 * i, v);
      end
      int_req <= 10'($random(seed));
      ext_n <= 4'($random(seed));
      repeat (3) @(posedge core_clk);
      lx = 3'h0;
      for (int l = 1; l < 8; l++) begin
        e = expect_ack(3'(l));
        if (e.spurious !== 1'b1) lx = 3'(l);
      end
      cmp(ipl, lx, "ipl");
      bus(1'b0, 32'h100, 0);
      cmp(rd, {18'h0, ~ext_n, int_req}, "pending");
      c = {$random(seed)} % 10;
      bus(1'b0, 32'h130 + 4 * c, 0);
      cmp(rd, src_sh[c], "source readback");
      ly = {$random(seed)} % 7 + 1;
      exp_q.push_back(expect_ack(lx));
      exp_q.push_back(expect_ack(ly));
      ipav_core_model_i.ack_pair(lx, ly);
    end
    repeat (3) @(posedge core_clk);
    cmp(exp_q.size(), 0, "missing ack");
    $display("priority and autovector test done");
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    cmp(ipl, 0, "ipl after second reset");
    bus(1'b0, 32'h110, 0);
    cmp(rd, 32'h3fff, "mask after second reset");
    bus(1'b0, 32'h120, 0);
    cmp(rd, 32'h0, "autovector after second reset");
    $display("mid-run reset test done");
    stop_test();
  end

  initial begin
    #200000;
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end
endmodule
